// >>> rf_link_defines.svh
// timing and framing constants shared by both ends of the radio link
// assumes a single 100 MHz ref_clk on both ends
`ifndef RF_LINK_DEFINES_SVH
`define RF_LINK_DEFINES_SVH

`define CLK_MHZ       100
`define CLK_HZ        100000000
// start-up uncertainty after enable, in microseconds
`define STARTUP_US    1000
`define STARTUP_CYC   (`STARTUP_US * `CLK_MHZ)
// carrier settle time before framing is trusted, in microseconds
`define SETTLE_US     500
`define SETTLE_CYC    (`SETTLE_US * `CLK_MHZ)
`define BAUD_DEFAULT  19200
`define OVERSAMPLE    16
`define DATA_BITS     8
`define FIFO_DEPTH    8
`define MID_SAMPLE    4'h7
`define LAST_SAMPLE   4'hf
`define LAST_BIT      3'h7

`endif

// >>> rf_link_pkg.sv
// types shared by the host end and the testbench
// assumes rf_link_defines.svh for the numeric constants
package rf_link_pkg;

  typedef logic [7:0] byte_type;

  // gray coded along idle, start, data, stop, hold
  typedef enum logic [2:0] {
    FRAME_IDLE  = 3'h0,
    FRAME_START = 3'h1,
    FRAME_DATA  = 3'h3,
    FRAME_STOP  = 3'h2,
    FRAME_HOLD  = 3'h6
  } frame_state_type;

endpackage

// >>> rf_link_if.sv
// pins between the radio receiver module and the host logic
// assumes both ends share ref_clk; the testbench joins the modports
interface rf_link_if;

  logic rxEnable;
  logic carrierDetect;
  logic dataOut;

  modport receiver
  (
    input  rxEnable,
    output carrierDetect,
    output dataOut
  );

  modport host
  (
    output rxEnable,
    input  carrierDetect,
    input  dataOut
  );

endinterface

// >>> rf_receiver_end.sv
// receiver module end: squelch gated carrier detect and data output
// assumes demodData and rfAboveSquelch come from logic on ref_clk
`include "rf_link_defines.svh"

module rf_receiver_end
#(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYC
)
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // link towards the host
  rf_link_if.receiver link,
  // radio side
  input  wire logic rfAboveSquelch,
  input  wire logic demodData
);

  localparam int unsigned CW = $clog2(STARTUP_CYCLES + 1);

  logic          enS1_q;
  logic          enS2_q;
  logic          enS3_q;
  logic          enable_q;
  logic [CW-1:0] startCnt_q;
  logic          settled;
  logic          cd_q;
  logic          data_q;

  // enable arrives on a pin: filtered, counts once two stages agree
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enS1_q   <= 1'b0;
      enS2_q   <= 1'b0;
      enS3_q   <= 1'b0;
      enable_q <= 1'b0;
    end
    else
    begin
      enS1_q <= link.rxEnable;
      enS2_q <= enS1_q;
      enS3_q <= enS2_q;
      if (enS2_q == enS3_q)
        enable_q <= enS3_q;
    end
  end

  assign settled = (startCnt_q == CW'(STARTUP_CYCLES));

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      startCnt_q <= '0;
    else if (!enable_q)
      startCnt_q <= '0;
    else if (!settled)
      startCnt_q <= startCnt_q + CW'(1);
  end

  // outputs held low rather than left unreliable while warming up
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cd_q   <= 1'b0;
      data_q <= 1'b0;
    end
    else
    begin
      cd_q   <= enable_q && settled && rfAboveSquelch;
      data_q <= enable_q && settled && rfAboveSquelch && demodData;
    end
  end

  assign link.carrierDetect = cd_q;
  assign link.dataOut       = data_q;

endmodule

// >>> serial_host_end.sv
// host end: carrier gated asynchronous receiver with byte buffer
// assumes the link pins come from another chip, sampled on ref_clk
// Contract
// - data line idles low without carrier
// - host inverts data line before framing
// - frame is start, eight data, stop
// - accept only after firm carrier detect
// - drop characters framed during carrier settling
// - begin at first start after settling
// - sender leads with two character periods carrier
// - every byte value passes without coding
// - discard byte without valid carrier detect
// - rising edge every 10 ms, high 50 us
// - nominal rate 2400 to 19200 baud
// - squelch above signal forces both low
// - host watches carrier and data together
// - filter line, not bare start edge
// - carrier detect high above squelch threshold
// - enable high runs module, low stops
// - ignore outputs 1 ms after enable
// - first good bit within 500 us
`include "rf_link_defines.svh"

module rx_fifo
#(
  parameter int unsigned WIDTH = `DATA_BITS,
  parameter int unsigned DEPTH = `FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
      if (pop)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
      if (push && !pop)
        count_q <= count_q + (AW+1)'(1);
      else if (pop && !push)
        count_q <= count_q - (AW+1)'(1);
    end
  end

endmodule

module serial_host_end
#(
  parameter int unsigned CLK_HZ         = `CLK_HZ,
  parameter int unsigned BAUD           = `BAUD_DEFAULT,
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYC,
  parameter int unsigned SETTLE_CYCLES  = `SETTLE_CYC,
  parameter int unsigned FIFO_DEPTH     = `FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // link towards the receiver module
  rf_link_if.host   link,
  // control and status
  input  wire logic hostEnable,
  output logic      carrierOk,
  output logic      dropPulse,
  // received bytes
  output logic      rxValid,
  input  wire logic rxReady,
  output rf_link_pkg::byte_type rxData
);

  localparam int unsigned DIV = CLK_HZ / (BAUD * `OVERSAMPLE);
  localparam int unsigned DW  = $clog2(DIV + 1);
  localparam int unsigned BW  = $clog2(STARTUP_CYCLES + 1);
  localparam int unsigned SW  = $clog2(SETTLE_CYCLES + 1);

  rf_link_pkg::frame_state_type state_q;
  rf_link_pkg::byte_type        shift_q;
  rf_link_pkg::byte_type        rxData_q;
  rf_link_pkg::byte_type        fifoData;
  logic [1:0]    pinS1_q;
  logic [1:0]    pinS2_q;
  logic [1:0]    pinS3_q;
  logic [1:0]    pinLvl_q;
  logic          rxEnable_q;
  logic [BW-1:0] blankCnt_q;
  logic [SW-1:0] settleCnt_q;
  logic [DW-1:0] tickCnt_q;
  logic [3:0]    sub_q;
  logic [2:0]    bitIdx_q;
  logic          startOk_q;
  logic          carrierOk_q;
  logic          dropPulse_q;
  logic          rxValid_q;
  logic          serial;
  logic          cdLevel;
  logic          blanked;
  logic          cdOk;
  logic          tick;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic          fifoOutReady;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rxEnable_q <= 1'b0;
    else
      rxEnable_q <= hostEnable;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pinS1_q  <= 2'h0;
      pinS2_q  <= 2'h0;
      pinS3_q  <= 2'h0;
      pinLvl_q <= 2'h0;
    end
    else
    begin
      pinS1_q  <= {link.carrierDetect, link.dataOut};
      pinS2_q  <= pinS1_q;
      pinS3_q  <= pinS2_q;
      pinLvl_q <= ((pinS2_q ~^ pinS3_q) & pinS3_q)
                | ((pinS2_q ^ pinS3_q) & pinLvl_q);
    end
  end

  assign cdLevel = pinLvl_q[1];
  assign serial  = ~pinLvl_q[0];

  assign blanked = (blankCnt_q != BW'(STARTUP_CYCLES));
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      blankCnt_q <= '0;
    else if (!rxEnable_q)
      blankCnt_q <= '0;
    else if (blanked)
      blankCnt_q <= blankCnt_q + BW'(1);
  end

  assign cdOk = (settleCnt_q == SW'(SETTLE_CYCLES));
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      settleCnt_q <= '0;
    else if (!rxEnable_q || blanked || !cdLevel)
      settleCnt_q <= '0;
    else if (!cdOk)
      settleCnt_q <= settleCnt_q + SW'(1);
  end

  assign tick = (tickCnt_q == DW'(DIV - 1));
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      tickCnt_q <= '0;
    else if (tick)
      tickCnt_q <= '0;
    else
      tickCnt_q <= tickCnt_q + DW'(1);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q   <= rf_link_pkg::FRAME_IDLE;
      sub_q     <= 4'h0;
      bitIdx_q  <= 3'h0;
      shift_q   <= 8'h00;
      startOk_q <= 1'b0;
      dropPulse_q <= 1'b0;
    end
    else
    begin
      dropPulse_q <= 1'b0;
      case (state_q)
        rf_link_pkg::FRAME_IDLE:
          if (tick && !serial)
          begin
            state_q <= rf_link_pkg::FRAME_START;
            sub_q   <= 4'h0;
          end
        rf_link_pkg::FRAME_START:
          if (tick)
          begin
            if (sub_q == `MID_SAMPLE)
            begin
              state_q  <= serial ? rf_link_pkg::FRAME_IDLE
                                 : rf_link_pkg::FRAME_DATA;
              sub_q    <= 4'h0;
              bitIdx_q <= 3'h0;
              startOk_q <= cdOk;
            end
            else
              sub_q <= sub_q + 4'h1;
          end
        rf_link_pkg::FRAME_DATA:
          if (tick)
          begin
            sub_q <= sub_q + 4'h1;
            if (sub_q == `LAST_SAMPLE)
            begin
              shift_q  <= {serial, shift_q[7:1]};
              bitIdx_q <= bitIdx_q + 3'h1;
              if (bitIdx_q == `LAST_BIT)
                state_q <= rf_link_pkg::FRAME_STOP;
            end
          end
        rf_link_pkg::FRAME_STOP:
          if (tick)
          begin
            sub_q <= sub_q + 4'h1;
            if (sub_q == `LAST_SAMPLE)
            begin
              if (serial && startOk_q && cdOk)
                state_q <= rf_link_pkg::FRAME_HOLD;
              else
              begin
                state_q     <= rf_link_pkg::FRAME_IDLE;
                dropPulse_q <= 1'b1;
              end
            end
          end
        rf_link_pkg::FRAME_HOLD:
          // back-pressure: a full buffer stalls the framer here
          if (fifoInReady)
            state_q <= rf_link_pkg::FRAME_IDLE;
        default:
          state_q <= rf_link_pkg::FRAME_IDLE;
      endcase
    end
  end

  rx_fifo
  #(
    .WIDTH (`DATA_BITS),
    .DEPTH (FIFO_DEPTH)
  )
  u_rx_fifo
  (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .inValid  (state_q == rf_link_pkg::FRAME_HOLD),
    .inReady  (fifoInReady),
    .inData   (shift_q),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoData)
  );

  // output register keeps rxData and rxValid straight from flops
  assign fifoOutReady = !rxValid_q || rxReady;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxValid_q   <= 1'b0;
      rxData_q    <= 8'h00;
      carrierOk_q <= 1'b0;
    end
    else
    begin
      carrierOk_q <= cdOk;
      if (fifoOutValid && fifoOutReady)
      begin
        rxValid_q <= 1'b1;
        rxData_q  <= fifoData;
      end
      else if (rxReady)
        rxValid_q <= 1'b0;
    end
  end

  assign link.rxEnable = rxEnable_q;
  assign carrierOk     = carrierOk_q;
  assign dropPulse     = dropPulse_q;
  assign rxValid       = rxValid_q;
  assign rxData        = rxData_q;

endmodule

// >>> rf_link_sva.sv
// checker for the pins between the receiver end and the host end
// assumes one clock and one reset shared by both ends
module rf_link_sva
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link pins and radio side
  input wire logic rxEnable,
  input wire logic carrierDetect,
  input wire logic dataOut,
  input wire logic rfAboveSquelch,
  input wire logic demodData
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_enableRise;
    $rose(rxEnable);
  endsequence
  sequence s_quiet;
    !carrierDetect [*8];
  endsequence
  sequence s_heldOff;
    !rxEnable [*6];
  endsequence

  property p_idleLow;
    !carrierDetect |-> !dataOut;
  endproperty
  property p_squelchFall;
    $fell(carrierDetect) |-> !dataOut;
  endproperty
  property p_squelchDrop;
    carrierDetect && !rfAboveSquelch |=> !carrierDetect && !dataOut;
  endproperty
  property p_disabled;
    s_heldOff |=> !carrierDetect && !dataOut;
  endproperty
  property p_warmUp;
    s_enableRise |-> s_quiet;
  endproperty
  property p_onlyAbove;
    carrierDetect |-> $past(rfAboveSquelch);
  endproperty
  property p_holds;
    carrierDetect && rfAboveSquelch && rxEnable |=> carrierDetect;
  endproperty
  property p_dataPasses;
    carrierDetect |-> dataOut == $past(demodData);
  endproperty

  a_idleLow: assert property (p_idleLow)
    else $error("data high without carrier");
  a_squelchFall: assert property (p_squelchFall)
    else $error("data high as carrier fell");
  a_squelchDrop: assert property (p_squelchDrop)
    else $error("outputs kept under squelch");
  a_disabled: assert property (p_disabled)
    else $error("outputs active while disabled");
  a_warmUp: assert property (p_warmUp)
    else $error("carrier during warm-up");
  a_onlyAbove: assert property (p_onlyAbove)
    else $error("carrier without signal");
  a_holds: assert property (p_holds)
    else $error("carrier lost above squelch");
  a_dataPasses: assert property (p_dataPasses)
    else $error("data altered");
endmodule

// >>> testbench.sv
// testbench joining the receiver end and the host end over the link
// assumes short warm-up and settle counts and a 4 cycle baud tick
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 64;

  logic                  ref_clk        = 1'b0;
  logic                  rstn           = 1'b0;
  logic                  hostEnable     = 1'b0;
  logic                  rxReady        = 1'b1;
  logic                  rfAboveSquelch = 1'b0;
  logic                  demodData      = 1'b0;
  logic                  carrierOk;
  logic                  dropPulse;
  logic                  rxValid;
  rf_link_pkg::byte_type rxData;
  int                    badCount       = 0;
  int                    numChecks      = 0;
  int                    dropCount      = 0;
  int                    cycles         = 0;
  rf_link_pkg::byte_type expQ[$];

  rf_link_if rf_link_if_inst ();

  rf_receiver_end #(.STARTUP_CYCLES(20)) rf_receiver_end_inst
  (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .link           (rf_link_if_inst.receiver),
    .rfAboveSquelch (rfAboveSquelch),
    .demodData      (demodData)
  );

  // clock lowered so one bit spans 64 cycles
  serial_host_end #(.CLK_HZ(1228800), .STARTUP_CYCLES(50),
    .SETTLE_CYCLES(40)) serial_host_end_inst
  (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .link       (rf_link_if_inst.host),
    .hostEnable (hostEnable),
    .carrierOk  (carrierOk),
    .dropPulse  (dropPulse),
    .rxValid    (rxValid),
    .rxReady    (rxReady),
    .rxData     (rxData)
  );

  rf_link_sva rf_link_sva_inst
  (
    .ref_clk        (ref_clk),
    .rstn           (rstn),
    .rxEnable       (rf_link_if_inst.rxEnable),
    .carrierDetect  (rf_link_if_inst.carrierDetect),
    .dataOut        (rf_link_if_inst.dataOut),
    .rfAboveSquelch (rfAboveSquelch),
    .demodData      (demodData)
  );

  always #5 ref_clk = ~ref_clk;

  task reportAndStop();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task checkBit(input string name, input logic exp, input logic got);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task checkByte(input rf_link_pkg::byte_type exp,
                 input rf_link_pkg::byte_type got);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch rxData expected %h seen %h", exp, got);
    end
  endtask

  task checkCount(input string name, input int exp, input int got);
    numChecks++;
    if (got != exp)
    begin
      badCount++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // line is inverted at the host: start is high, data bits go out inverted
  task sendByte(input rf_link_pkg::byte_type b, input int cutAt);
    int i;
    demodData <= 1'b1;
    repeat (BIT_CYC) @(posedge ref_clk);
    for (i = 0; i < 8; i++)
    begin
      if (i == cutAt)
        rfAboveSquelch <= 1'b0;
      demodData <= ~b[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
    demodData <= 1'b0;
    repeat (BIT_CYC) @(posedge ref_clk);
  endtask

  // handshake judged at the falling edge, before the taking edge
  always @(negedge ref_clk)
  begin
    if (dropPulse === 1'b1)
      dropCount++;
    if (rxValid === 1'b1 && rxReady === 1'b1)
    begin
      if (expQ.size() == 0)
        checkBit("spare byte", 1'b0, 1'b1);
      else
        checkByte(expQ.pop_front(), rxData);
    end
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      badCount++;
      reportAndStop();
    end
  end

  task testQuiet();
    hostEnable <= 1'b1;
    repeat (100) @(posedge ref_clk);
    demodData <= 1'b1;
    repeat (20) @(posedge ref_clk);
    checkBit("dataOut", 1'b0, rf_link_if_inst.dataOut);
    checkBit("carrierDetect", 1'b0, rf_link_if_inst.carrierDetect);
    demodData <= 1'b0;
    repeat (BIT_CYC) @(posedge ref_clk);
    checkCount("drops", 0, dropCount);
    $display("quiet test done");
  endtask

  task testFirstDropped();
    rf_link_pkg::byte_type vals[3];
    vals = '{8'h00, 8'hff, 8'ha5};
    rfAboveSquelch <= 1'b1;
    sendByte(8'h5a, 8);
    repeat (10 * BIT_CYC) @(posedge ref_clk);
    checkCount("drops", 1, dropCount);
    checkBit("carrierOk", 1'b1, carrierOk);
    foreach (vals[k])
    begin
      expQ.push_back(vals[k]);
      sendByte(vals[k], 8);
    end
    repeat (40) @(posedge ref_clk);
    checkCount("bytes left", 0, expQ.size());
    $display("first byte test done");
  endtask

  task testFifoFull();
    rxReady <= 1'b0;
    // ten bytes: output register and buffer fill, the last waits in hold
    for (int k = 0; k < 10; k++)
    begin
      expQ.push_back(8'(k * 33 + 5));
      sendByte(8'(k * 33 + 5), 8);
    end
    repeat (40) @(posedge ref_clk);
    checkBit("rxValid", 1'b1, rxValid);
    checkByte(8'h05, rxData);
    rxReady <= 1'b1;
    repeat (40) @(posedge ref_clk);
    checkCount("bytes left", 0, expQ.size());
    $display("buffer test done");
  endtask

  task testCarrierLoss();
    sendByte(8'h3c, 4);
    repeat (40) @(posedge ref_clk);
    checkCount("drops", 2, dropCount);
    checkBit("carrierOk", 1'b0, carrierOk);
    $display("carrier loss test done");
  endtask

  task testDisable();
    rfAboveSquelch <= 1'b1;
    hostEnable <= 1'b0;
    repeat (20) @(posedge ref_clk);
    checkBit("rxEnable", 1'b0, rf_link_if_inst.rxEnable);
    checkBit("carrierDetect", 1'b0, rf_link_if_inst.carrierDetect);
    // re-enable with signal present: low through warm-up, then follows
    hostEnable <= 1'b1;
    repeat (10) @(posedge ref_clk);
    checkBit("carrierDetect", 1'b0, rf_link_if_inst.carrierDetect);
    repeat (30) @(posedge ref_clk);
    checkBit("carrierDetect", 1'b1, rf_link_if_inst.carrierDetect);
    checkBit("dataOut", 1'b0, rf_link_if_inst.dataOut);
    $display("disable test done");
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    testQuiet();
    testFirstDropped();
    testFifoFull();
    testCarrierLoss();
    testDisable();
    reportAndStop();
  end
endmodule
